// ===== sarib_pkg.sv
// Shared constants for the scan rate and input buffer block
package sarib_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam int REG_AW = 8;
   localparam logic [7:0] OFS_INPUT_SAMPLE = 8'h08;
   localparam logic [7:0] OFS_BUF_CONTROL = 8'h0C;
   localparam logic [7:0] OFS_RATE_A = 8'h10;
   localparam logic [7:0] OFS_RATE_B = 8'h14;
   localparam logic [7:0] OFS_SCAN_SYNC = 8'h20;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int POS_CLEAR = 15;
   localparam int POS_THR_FLAG = 16;
   localparam int POS_TAG = 16;
   localparam int POS_GEN_DISABLE = 16;
   localparam int POS_SCAN_CLK = 2;
   localparam int POS_SYNC_OUT = 8;
   localparam int POS_RATE_B_SRC = 10;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [31:0] RST_BUF_CONTROL = 32'h0000_7FFE;
   localparam logic [31:0] RST_RATE_A = 32'h0001_09C4;
   localparam logic [31:0] RST_RATE_B = 32'h0001_0064;
   localparam logic [31:0] RST_SCAN_SYNC = 32'h0000_02D1;
   localparam logic [31:0] SCAN_SYNC_MASK = 32'h0003_FFFF;
   // ----------------------------------------
   // Sizes and timing
   // ----------------------------------------
   localparam int XFER_AW = 8;
   localparam int BUF_AW = 15;
   localparam int MASTER_HZ = 30_000_000;
   localparam int CLEAR_CYCLES = 2;
   // Source selections
   localparam logic [1:0] SRC_RATE_A = 2'h0;
   localparam logic [1:0] SRC_RATE_B = 2'h1;
   localparam logic [1:0] SRC_EXT_SYNC = 2'h2;
   localparam logic [1:0] SRC_SOFT = 2'h3;
endpackage : sarib_pkg

// ===== sarib_fifo_if.sv
// Interface between the block and one of its FIFO stores
`timescale 1ns/1ps
`default_nettype none
interface sarib_fifo_if #(parameter int W = 17, parameter int AW = 8);
   logic push;
   logic [W-1:0] push_data;
   logic pop;
   logic [W-1:0] pop_data;
   logic clear;
   logic full;
   logic empty;
   logic [AW:0] count;
   modport user(output push, push_data, pop, clear, input pop_data, full, empty, count);
   modport store(input push, push_data, pop, clear, output pop_data, full, empty, count);
endinterface : sarib_fifo_if
`default_nettype wire

// ===== sarib_rate_gen.sv
// Programmable 16-bit rate generator
`timescale 1ns/1ps
`default_nettype none
module sarib_rate_gen (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Control
   input wire logic tick,
   input wire logic gen_disable,
   input wire logic [15:0] divisor,
   // Output
   output logic pulse
);
   logic [15:0] count_reg;
   logic run_reg;

   // Down-counter reloads from divisor on expiry
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count_reg <= 16'h0000;
         run_reg <= 1'b0;
         pulse <= 1'b0;
      end else if (gen_disable) begin
         count_reg <= divisor;
         run_reg <= 1'b0;
         pulse <= 1'b0;
      end else if (!run_reg) begin
         // First enabled cycle reloads, so a divisor written with the enable applies
         count_reg <= divisor;
         run_reg <= 1'b1;
         pulse <= 1'b0;
      end else begin
         pulse <= 1'b0;
         if (tick) begin
            if (count_reg <= 16'h0001) begin
               count_reg <= divisor;
               pulse <= 1'b1;
            end else begin
               count_reg <= count_reg - 16'h0001;
            end
         end
      end
   end
endmodule : sarib_rate_gen
`default_nettype wire

// ===== sarib_fifo.sv
// Parameterised FIFO store with clear and occupancy count
`timescale 1ns/1ps
`default_nettype none
module sarib_fifo #(parameter int W = 17, parameter int AW = 8) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Store side
   sarib_fifo_if.store port
);
   localparam int DEPTH = 1 << AW;
   localparam logic [AW:0] FULL_COUNT = {1'b1, {AW{1'b0}}};
   logic [W-1:0] mem [0:DEPTH-1];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic do_push;
   logic do_pop;

   // Full blocks writes so stored data stays intact
   assign do_push = port.push && !port.full && !port.clear;
   assign do_pop = port.pop && !port.empty && !port.clear;
   assign port.full = (count_reg == FULL_COUNT);
   assign port.empty = (count_reg == '0);
   assign port.count = count_reg;
   assign port.pop_data = mem[rd_ptr_reg];

   // Storage array
   always_ff @(posedge clk) begin
      if (do_push) begin
         mem[wr_ptr_reg] <= port.push_data;
      end
   end

   // Pointers and count
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else if (port.clear) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (do_push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (do_pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
         if (do_push && !do_pop) count_reg <= count_reg + 1'b1;
         else if (do_pop && !do_push) count_reg <= count_reg - 1'b1;
      end
   end
endmodule : sarib_fifo
`default_nettype wire

// ===== sarib_top.sv
// Scan rate generators and analog input buffer
`timescale 1ns/1ps
`default_nettype none
module sarib_top
   import sarib_pkg::*;
#(
   parameter int XFER_ADDR_W = XFER_AW,
   parameter int BUF_ADDR_W = BUF_AW
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Register port
   input wire logic [REG_AW-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   // Board control bits
   input wire logic offset_binary,
   input wire logic input_sync_bit,
   input wire logic thresh_irq_falling,
   // Converter sample stream
   input wire logic sample_valid,
   input wire logic [15:0] sample_data,
   input wire logic [4:0] sample_chan,
   // Sync lines
   input wire logic ext_sync_in,
   input wire logic out_burst_sync,
   output logic ext_sync_out,
   // Scan control and clocks
   output logic scan_start,
   output logic scan_abort,
   output logic rate_a_out,
   output logic rate_b_out,
   // Threshold status
   output logic thresh_flag,
   output logic thresh_irq_event
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   localparam logic [1:0] CLEAR_LAST = 2'(CLEAR_CYCLES - 1);
   logic [31:0] rate_a_reg;
   logic [31:0] rate_b_reg;
   logic [31:0] scan_sync_reg;
   logic [14:0] threshold_reg;
   logic clear_busy_reg;
   logic [1:0] clear_cnt_reg;
   logic ext_sync_prev_reg;
   logic soft_sync_prev_reg;
   logic thresh_prev_reg;
   logic pulse_a;
   logic pulse_b;
   logic tick_b;
   logic scan_event;
   logic sync_out_next;
   logic [1:0] scan_src;
   logic [1:0] sync_src;
   logic wr_rate_a;
   logic wr_rate_b;
   logic wr_scan;
   logic wr_control;
   logic rd_sample;
   logic [16:0] head_word;
   logic [31:0] rd_next;
   logic thresh_next;

   sarib_fifo_if #(.W(17), .AW(XFER_ADDR_W)) xfer_if ();
   sarib_fifo_if #(.W(17), .AW(BUF_ADDR_W)) buf_if ();

   // ----------------------------------------
   // Register write decode
   // ----------------------------------------
   // Only writable offsets decode; sample port writes do nothing
   assign wr_rate_a = reg_wr && (reg_addr == OFS_RATE_A);
   assign wr_rate_b = reg_wr && (reg_addr == OFS_RATE_B);
   assign wr_scan = reg_wr && (reg_addr == OFS_SCAN_SYNC);
   assign wr_control = reg_wr && (reg_addr == OFS_BUF_CONTROL);
   assign rd_sample = reg_rd && (reg_addr == OFS_INPUT_SAMPLE);

   // Rate registers, inactive bits held at zero
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rate_a_reg <= RST_RATE_A;
         rate_b_reg <= RST_RATE_B;
      end else begin
         if (wr_rate_a) rate_a_reg <= {15'h0000, reg_wdata[16:0]};
         if (wr_rate_b) rate_b_reg <= {15'h0000, reg_wdata[16:0]};
      end
   end

   // Scan and sync configuration
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scan_sync_reg <= RST_SCAN_SYNC;
      end else if (wr_scan) begin
         scan_sync_reg <= reg_wdata & SCAN_SYNC_MASK;
      end
   end

   assign scan_src = scan_sync_reg[POS_SCAN_CLK +: 2];
   assign sync_src = scan_sync_reg[POS_SYNC_OUT +: 2];

   // Threshold field
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         threshold_reg <= RST_BUF_CONTROL[14:0];
      end else if (wr_control) begin
         threshold_reg <= reg_wdata[14:0];
      end
   end

   // ----------------------------------------
   // Buffer clear sequence
   // ----------------------------------------
   // Clear stays busy for a fixed number of cycles, then drops
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         clear_busy_reg <= RST_BUF_CONTROL[POS_CLEAR];
         clear_cnt_reg <= 2'h0;
      end else if (wr_control && reg_wdata[POS_CLEAR]) begin
         clear_busy_reg <= 1'b1;
         clear_cnt_reg <= 2'h0;
      end else if (clear_busy_reg) begin
         if (clear_cnt_reg == CLEAR_LAST) begin
            clear_busy_reg <= 1'b0;
         end else begin
            clear_cnt_reg <= clear_cnt_reg + 2'h1;
         end
      end
   end

   // Abort pulse for the scan sequencer
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scan_abort <= 1'b0;
      end else begin
         scan_abort <= wr_control && reg_wdata[POS_CLEAR];
      end
   end

   // ----------------------------------------
   // Rate generators
   // ----------------------------------------
   // Second generator can count first generator pulses
   assign tick_b = scan_sync_reg[POS_RATE_B_SRC] ? pulse_a : 1'b1;

   sarib_rate_gen u_rate_a (
      .clk(clk),
      .reset_n(reset_n),
      .tick(1'b1),
      .gen_disable(rate_a_reg[POS_GEN_DISABLE]),
      .divisor(rate_a_reg[15:0]),
      .pulse(pulse_a)
   );

   sarib_rate_gen u_rate_b (
      .clk(clk),
      .reset_n(reset_n),
      .tick(tick_b),
      .gen_disable(rate_b_reg[POS_GEN_DISABLE]),
      .divisor(rate_b_reg[15:0]),
      .pulse(pulse_b)
   );

   // Registered generator outputs for the output path
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rate_a_out <= 1'b0;
         rate_b_out <= 1'b0;
      end else begin
         rate_a_out <= pulse_a;
         rate_b_out <= pulse_b;
      end
   end

   // ----------------------------------------
   // Scan clock selection
   // ----------------------------------------
   // Edge history for sync line and software sync bit
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ext_sync_prev_reg <= 1'b0;
         soft_sync_prev_reg <= 1'b0;
      end else begin
         ext_sync_prev_reg <= ext_sync_in;
         soft_sync_prev_reg <= input_sync_bit;
      end
   end

   // Chosen source event starts a scan
   always_comb begin
      case (scan_src)
         SRC_RATE_A: scan_event = pulse_a;
         SRC_RATE_B: scan_event = pulse_b;
         SRC_EXT_SYNC: scan_event = ext_sync_prev_reg && !ext_sync_in;
         SRC_SOFT: scan_event = input_sync_bit && !soft_sync_prev_reg;
         default: scan_event = 1'b0;
      endcase
   end

   // Scan start held off while a clear runs
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scan_start <= 1'b0;
      end else begin
         scan_start <= scan_event && !clear_busy_reg;
      end
   end

   // ----------------------------------------
   // External sync output
   // ----------------------------------------
   always_comb begin
      case (sync_src)
         2'h0: sync_out_next = scan_event;
         2'h1: sync_out_next = out_burst_sync;
         SRC_EXT_SYNC: sync_out_next = ext_sync_in;
         default: sync_out_next = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ext_sync_out <= 1'b0;
      end else begin
         ext_sync_out <= sync_out_next;
      end
   end

   // ----------------------------------------
   // Sample data path
   // ----------------------------------------
   // Transfer FIFO takes tagged samples; full drops them
   assign xfer_if.push = sample_valid && !clear_busy_reg;
   assign xfer_if.push_data = {(sample_chan == 5'h00), sample_data};
   assign xfer_if.clear = clear_busy_reg;
   assign xfer_if.pop = !buf_if.full && !xfer_if.empty;

   // Buffer fills from the transfer FIFO, drained by reads
   assign buf_if.push = xfer_if.pop;
   assign buf_if.push_data = xfer_if.pop_data;
   assign buf_if.clear = clear_busy_reg;
   assign buf_if.pop = rd_sample;

   sarib_fifo #(.W(17), .AW(XFER_ADDR_W)) u_xfer (
      .clk(clk),
      .reset_n(reset_n),
      .port(xfer_if)
   );

   sarib_fifo #(.W(17), .AW(BUF_ADDR_W)) u_buf (
      .clk(clk),
      .reset_n(reset_n),
      .port(buf_if)
   );

   // Coding applied on the way out: MSB flips for two's complement
   assign head_word = {buf_if.pop_data[16],
                       buf_if.pop_data[15] ^ !offset_binary,
                       buf_if.pop_data[14:0]};

   // ----------------------------------------
   // Register read path
   // ----------------------------------------
   always_comb begin
      rd_next = 32'h0000_0000;
      case (reg_addr)
         OFS_INPUT_SAMPLE: begin
            if (!buf_if.empty && !clear_busy_reg) begin
               rd_next = {15'h0000, head_word};
            end else begin
               rd_next = 32'h0000_0000;
            end
         end
         OFS_BUF_CONTROL: begin
            rd_next = {15'h0000, thresh_flag, clear_busy_reg, threshold_reg};
         end
         OFS_RATE_A: rd_next = rate_a_reg;
         OFS_RATE_B: rd_next = rate_b_reg;
         OFS_SCAN_SYNC: rd_next = scan_sync_reg;
         default: rd_next = 32'h0000_0000;
      endcase
   end

   // Read data captured one cycle after the strobe
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         reg_rdata <= rd_next;
      end
   end

   // ----------------------------------------
   // Threshold flag and interrupt event
   // ----------------------------------------
   // Only buffer occupancy counts, not the transfer FIFO
   assign thresh_next = buf_if.count > {1'b0, threshold_reg};

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         thresh_flag <= 1'b0;
         thresh_prev_reg <= 1'b0;
      end else begin
         thresh_flag <= thresh_next;
         thresh_prev_reg <= thresh_flag;
      end
   end

   // One-cycle event on the selected edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         thresh_irq_event <= 1'b0;
      end else if (thresh_irq_falling) begin
         thresh_irq_event <= thresh_prev_reg && !thresh_flag;
      end else begin
         thresh_irq_event <= thresh_flag && !thresh_prev_reg;
      end
   end
endmodule : sarib_top
`default_nettype wire

// ===== sarib_top_assertions.sv
// Concurrent checks on the ports of the scan rate and input buffer block
`timescale 1ns/1ps
`default_nettype none
module sarib_top_chk
   import sarib_pkg::*;
#(
   parameter int XFER_ADDR_W = XFER_AW,
   parameter int BUF_ADDR_W = BUF_AW
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Register port
   input wire logic [REG_AW-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   // Control bits and sample stream
   input wire logic offset_binary,
   input wire logic input_sync_bit,
   input wire logic thresh_irq_falling,
   input wire logic sample_valid,
   input wire logic [15:0] sample_data,
   input wire logic [4:0] sample_chan,
   // Sync, scan and status
   input wire logic ext_sync_in,
   input wire logic out_burst_sync,
   input wire logic ext_sync_out,
   input wire logic scan_start,
   input wire logic scan_abort,
   input wire logic rate_a_out,
   input wire logic rate_b_out,
   input wire logic thresh_flag,
   input wire logic thresh_irq_event
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // ----------------------------------------
   // Helper logic
   // ----------------------------------------
   logic dis_a_reg;
   logic dis_b_reg;
   logic clr_wr;
   // Clear request seen on the register port
   assign clr_wr = reg_wr && reg_addr == OFS_BUF_CONTROL && reg_wdata[POS_CLEAR];
   // Shadow of both generator disable bits
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dis_a_reg <= 1'b1;
         dis_b_reg <= 1'b1;
      end else if (reg_wr) begin
         if (reg_addr == OFS_RATE_A) dis_a_reg <= reg_wdata[POS_GEN_DISABLE];
         if (reg_addr == OFS_RATE_B) dis_b_reg <= reg_wdata[POS_GEN_DISABLE];
      end
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   AST_RDATA_HI: assert property ($past(reg_rd) && $past(reg_addr) == OFS_INPUT_SAMPLE
      |-> reg_rdata[31:17] == 15'h0000) else $error("sample word upper bits not zero");
   AST_ABORT: assert property (clr_wr |=> scan_abort ##1 !scan_abort)
      else $error("no single abort pulse after clear");
   AST_CLR_FLAG: assert property (clr_wr |-> ##[1:4] !thresh_flag)
      else $error("threshold flag stays high after clear");
   AST_RATE_A_OFF: assert property (dis_a_reg && $past(dis_a_reg) |-> !rate_a_out)
      else $error("disabled generator A pulses");
   AST_RATE_B_OFF: assert property (dis_b_reg && $past(dis_b_reg) |-> !rate_b_out)
      else $error("disabled generator B pulses");
   // Bench keeps the sync output source at passthrough
   AST_SYNC_PASS: assert property (ext_sync_out == $past(ext_sync_in))
      else $error("sync output does not follow sync input");
   // Bench keeps the scan clock source at generator A
   AST_SCAN_SRC: assert property (scan_start |-> rate_a_out)
      else $error("scan start without generator pulse");
   AST_IRQ_RISE: assert property ($rose(thresh_flag) && !thresh_irq_falling
      |-> ##[0:1] thresh_irq_event) else $error("no event on flag rise");
   AST_IRQ_FALL: assert property ($fell(thresh_flag) && thresh_irq_falling
      |-> ##[0:1] thresh_irq_event) else $error("no event on flag fall");
   // Main scenarios reached
   cover property (scan_abort);
   cover property (thresh_irq_event);
   cover property (scan_start);
endmodule : sarib_top_chk
bind sarib_top sarib_top_chk #(.XFER_ADDR_W(XFER_ADDR_W), .BUF_ADDR_W(BUF_ADDR_W)) u_chk (
   .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .offset_binary(offset_binary),
   .input_sync_bit(input_sync_bit), .thresh_irq_falling(thresh_irq_falling),
   .sample_valid(sample_valid), .sample_data(sample_data), .sample_chan(sample_chan),
   .ext_sync_in(ext_sync_in), .out_burst_sync(out_burst_sync), .ext_sync_out(ext_sync_out),
   .scan_start(scan_start), .scan_abort(scan_abort), .rate_a_out(rate_a_out),
   .rate_b_out(rate_b_out), .thresh_flag(thresh_flag), .thresh_irq_event(thresh_irq_event));
`default_nettype wire

// ===== sarib_host_model.sv
// Host register master model for the scan rate and input buffer block
`timescale 1ns/1ps
`default_nettype none
module sarib_host_model
   import sarib_pkg::*;
(
   // Clock
   input wire logic clk,
   // Register port
   output logic [REG_AW-1:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata
);
   // Idle bus from time zero
   initial begin
      reg_addr = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = '0;
   end
   // One-cycle write strobe; data inverted after so nothing stale lingers
   task automatic wr(input logic [REG_AW-1:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask : wr
   // One-cycle read strobe; data taken once the answer edge has landed
   task automatic rd(input logic [REG_AW-1:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
endmodule : sarib_host_model
`default_nettype wire

// ===== test_scan_rate_and_input_buffer.sv
// Self-checking bench for the scan rate and input buffer block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
   $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module test_scan_rate_and_input_buffer;
   import sarib_pkg::*;
   localparam int XW = 4;
   localparam int BW = 4;
   localparam logic [15:0] DIV_A = 16'h0320;
   localparam logic [15:0] DIV_B = 16'h0003;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [REG_AW-1:0] reg_addr;
   logic reg_wr, reg_rd;
   logic [31:0] reg_wdata, reg_rdata, rv;
   logic offset_binary = 1'b1;
   logic thresh_irq_falling = 1'b0;
   logic sample_valid = 1'b0;
   logic [15:0] sample_data = 16'h0000;
   logic [4:0] sample_chan = 5'h00;
   logic ext_sync_in = 1'b0;
   logic ext_sync_out, scan_start, scan_abort, rate_a_out, rate_b_out;
   logic thresh_flag, thresh_irq_event;
   logic [1:0] rates;
   int error_cnt = 0;
   int samples_checked = 0;
   int n;
   assign rates = {rate_b_out, rate_a_out};
   // Clock, 25 ns period
   always #12.5 clk = ~clk;
   sarib_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   sarib_top #(.XFER_ADDR_W(XW), .BUF_ADDR_W(BW)) dut (.clk(clk), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .offset_binary(offset_binary), .input_sync_bit(1'b0),
      .thresh_irq_falling(thresh_irq_falling), .sample_valid(sample_valid),
      .sample_data(sample_data), .sample_chan(sample_chan), .ext_sync_in(ext_sync_in),
      .out_burst_sync(1'b0), .ext_sync_out(ext_sync_out), .scan_start(scan_start),
      .scan_abort(scan_abort), .rate_a_out(rate_a_out), .rate_b_out(rate_b_out),
      .thresh_flag(thresh_flag), .thresh_irq_event(thresh_irq_event));
   // Verdict and end of run
   task automatic conclude();
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude
   // One converter sample
   task automatic push(input logic [15:0] d, input logic [4:0] c);
      @(posedge clk);
      sample_valid <= 1'b1;
      sample_data <= d;
      sample_chan <= c;
      @(posedge clk);
      sample_valid <= 1'b0;
      sample_data <= ~d;
   endtask : push
   // Register read with expected value
   task automatic rchk(input logic [REG_AW-1:0] a, input logic [31:0] e);
      logic [31:0] d;
      host.rd(a, d);
      `CHK(d, e)
   endtask : rchk
   // Cycles between two pulses of one generator
   task automatic gap(input int b, input int e);
      int k;
      for (int p = 0; p < 2; p++) begin
         k = 0;
         do begin @(posedge clk); k++; end while (rates[b] !== 1'b1 && k < 6000);
      end
      `CHK(k, e)
   endtask : gap
   // Hang guard
   initial begin
      #(25 * 40000);
      error_cnt++;
      conclude();
   end
   // Main sequence
   initial begin
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      rchk(OFS_BUF_CONTROL, RST_BUF_CONTROL);
      rchk(OFS_RATE_A, RST_RATE_A);
      rchk(OFS_RATE_B, RST_RATE_B);
      rchk(OFS_SCAN_SYNC, RST_SCAN_SYNC);
      rchk(8'h04, 32'h0000_0000);
      host.wr(OFS_INPUT_SAMPLE, 32'h0001_5A5A);
      rchk(OFS_INPUT_SAMPLE, 32'h0000_0000);
      host.wr(OFS_RATE_A, 32'hFFFF_FFFF);
      rchk(OFS_RATE_A, 32'h0001_FFFF);
      host.wr(OFS_BUF_CONTROL, 32'hFFFF_7FFF);
      rchk(OFS_BUF_CONTROL, 32'h0000_7FFF);
      // Sync passthrough
      @(posedge clk) ext_sync_in <= 1'b1;
      repeat (2) @(posedge clk);
      #1 `CHK(ext_sync_out, 1'b1)
      // Threshold, tag and coding
      host.wr(OFS_BUF_CONTROL, 32'h0000_0001);
      push(16'h8000, 5'h00);
      push(16'h1234, 5'h05);
      repeat (4) @(posedge clk);
      #1 `CHK(thresh_flag, 1'b1)
      @(posedge clk) thresh_irq_falling <= 1'b1;
      offset_binary <= 1'b0;
      rchk(OFS_INPUT_SAMPLE, 32'h0001_0000);
      repeat (3) @(posedge clk);
      #1 `CHK(thresh_flag, 1'b0)
      @(posedge clk) offset_binary <= 1'b1;
      rchk(OFS_INPUT_SAMPLE, 32'h0000_1234);
      rchk(OFS_INPUT_SAMPLE, 32'h0000_0000);
      // Clear with data held
      for (int i = 0; i < 3; i++) push(16'h0100 + 16'(i), 5'h01);
      repeat (3) @(posedge clk);
      host.wr(OFS_BUF_CONTROL, 32'h0000_8001);
      n = 0;
      do begin host.rd(OFS_BUF_CONTROL, rv); n++; end while (rv[POS_CLEAR] !== 1'b0 && n < 8);
      `CHK(rv, 32'h0000_0001)
      rchk(OFS_INPUT_SAMPLE, 32'h0000_0000);
      // Generator rates, scan starts, cascade
      host.wr(OFS_RATE_A, {16'h0000, DIV_A});
      gap(0, DIV_A);
      n = 0;
      repeat (2 * DIV_A) begin @(posedge clk); if (scan_start === 1'b1) n++; end
      `CHK(n, 2)
      host.wr(OFS_SCAN_SYNC, RST_SCAN_SYNC | 32'h0000_0400);
      host.wr(OFS_RATE_B, {16'h0000, DIV_B});
      gap(1, DIV_A * DIV_B);
      // Overfill, then drain in order
      for (int i = 1; i <= 40; i++) push(16'(i), 5'h02);
      repeat (4) @(posedge clk);
      n = 0;
      rv = 32'h0000_0001;
      while (rv !== 32'h0000_0000 && n < 40) begin
         host.rd(OFS_INPUT_SAMPLE, rv);
         if (rv !== 32'h0000_0000) begin n++; `CHK(rv, 32'(n)) end
      end
      `CHK(n >= 32 && n <= 33, 1'b1)
      conclude();
   end
endmodule : test_scan_rate_and_input_buffer
`default_nettype wire
